// ### light_threshold_alert_logic_test.sv
/*
 * self-checking bench of the threshold alert block: apb register tasks,
 * conversion strobes, a read monitor fed from a queue of expectations.
 * assumes one wait state apb slave and the host model on the alert wire.
 */
`timescale 1ns/1ps
module light_threshold_alert_logic_test;
	import ltal_pkg::*;
	// -------------------------------------------------------------
	// signals
	// -------------------------------------------------------------
	logic        clk, rst, psel, penable, pwrite, conv_valid;
	logic [31:0] paddr, pwdata;
	logic [31:0] prdata;
	logic        pready, pslverr, alert_o, alert_oe, irq, alert_wire;
	ltal_meas_t  conv_data;
	logic [32:0] exp_q[$];
	int          fail_count, checks_done;
	integer      seed;
	logic [32:0] e;
	logic [15:0] lim_ok;

	// 200 MHz reference clock
	always #2.5 clk = ~clk;

	ltal_top #(.ID_VALUE(16'h2b6d)) i_dut ( // arbitrary identification value
		.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_conv_valid(conv_valid),
		.i_conv_data(conv_data), .o_alert_o(alert_o), .o_alert_oe(alert_oe), .o_irq(irq));
	ltal_host_model i_host (.i_alert_o(alert_o), .i_alert_oe(alert_oe), .o_alert_wire(alert_wire));

	// -------------------------------------------------------------
	// read monitor: oldest expectation against each completed read
	// -------------------------------------------------------------
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
			checks_done++;
			if ({pslverr, prdata} !== e) begin
				fail_count++;
				$display("MISMATCH read %h expected %h seen %h", paddr, e, {pslverr, prdata});
			end
		end
	end

	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	// waits for pready with no cycle count assumed; the watchdog ends a hang
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0, d});
	endtask
	task automatic rd(input logic [31:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	// flags land one edge after the strobe, the pin one edge later
	task automatic conv(input logic [15:0] d);
		@(posedge clk);
		conv_valid <= 1'b1; conv_data <= d;
		@(posedge clk);
		conv_valid <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [1:0] x, input logic [1:0] s);
		checks_done++;
		if (s !== x) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic complete_run();
		if (exp_q.size() != 0) fail_count++;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog at 20000 cycles, about fifty times the length of the sequence
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		conv_valid = 0; conv_data = '0; fail_count = 0; checks_done = 0; seed = 32'h0b517977;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// reset values, id and an unmapped place
		rd(ADDR_CONFIG, 33'h0c010);
		rd(ADDR_LOW_LIM, 33'h0);
		rd(ADDR_HIGH_LIM, 33'h0bfff);
		rd(ADDR_IRQ_STAT, 33'h0);
		rd(ADDR_IRQ_MASK, 33'h0);
		rd(ADDR_ID, 33'h02b6d);
		rd(32'h40, 33'h100000000);
		$display("test reset done");
		// limits: low 16, high 256; trip codes in transparent mode
		wr(ADDR_LOW_LIM, 16'h0010);
		wr(ADDR_HIGH_LIM, 16'h0100);
		for (int t = 0; t < 4; t++) begin
			wr(ADDR_CONFIG, 16'hc000 | 16'(t));
			repeat ((1 << t) - 1) conv(16'h0001);
			lim_ok = 16'h0020 | 16'($random(seed) & 32'h7f);
			conv(lim_ok);
			repeat ((1 << t) - 1) conv(16'h0001);
			rd(ADDR_CONFIG, {17'h0, 16'hc000 | 16'(t)});
			chk("alert_idle", 2'b01, {alert_oe, alert_wire});
			conv(16'h0001);
			rd(ADDR_CONFIG, {17'h0, 16'hc020 | 16'(t)});
			chk("alert_low", 2'b10, {alert_oe, alert_wire});
			conv(lim_ok);
			rd(ADDR_CONFIG, {17'h0, 16'hc000 | 16'(t)});
		end
		$display("test trip counts done");
		// inverted polarity with an over-limit result
		wr(ADDR_CONFIG, 16'hc008);
		conv(16'h0200);
		rd(ADDR_CONFIG, 33'h0c048);
		chk("alert_inv", 2'b01, {alert_oe, alert_wire});
		conv(16'h0050);
		rd(ADDR_CONFIG, 33'h0c008);
		chk("alert_inv_idle", 2'b10, {alert_oe, alert_wire});
		$display("test polarity done");
		// interrupt: raise, mask, clear
		wr(ADDR_CONFIG, 16'hc000);
		wr(ADDR_IRQ_STAT, 16'h0007);
		wr(ADDR_IRQ_MASK, 16'h0001);
		conv(16'h0200);
		chk("irq_set", 2'b01, {1'b0, irq});
		rd(ADDR_IRQ_STAT, 33'h5);
		wr(ADDR_IRQ_MASK, 16'h0000);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_masked", 2'b00, {1'b0, irq});
		wr(ADDR_IRQ_MASK, 16'h0001);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_unmasked", 2'b01, {1'b0, irq});
		wr(ADDR_IRQ_STAT, 16'h0001);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_cleared", 2'b00, {1'b0, irq});
		rd(ADDR_IRQ_STAT, 33'h4);
		$display("test interrupt done");
		// retention: flag held past a good result, cleared by the read
		wr(ADDR_CONFIG, 16'hc010);
		conv(16'h0200);
		conv(16'h0050);
		chk("alert_held", 2'b10, {alert_oe, alert_wire});
		rd(ADDR_CONFIG, 33'h0c050);
		rd(ADDR_CONFIG, 33'h0c010);
		$display("test retention done");
		// exponent zeroing: manual range masks the report, not the compare
		wr(ADDR_HIGH_LIM, 16'h0200);
		wr(ADDR_CONFIG, 16'h5004);
		conv(16'h3100);
		rd(ADDR_RESULT, 33'h0100);
		rd(ADDR_CONFIG, 33'h05044);
		wr(ADDR_CONFIG, 16'hc004);
		conv(16'h3100);
		rd(ADDR_RESULT, 33'h3100);
		$display("test exponent done");
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule

// ### ltal_host_model.sv
/*
 * host-side model of the alert wire: open-drain wire with pull-up, as the
 * host controller sees it.
 * assumes the device drives o_alert_o low while o_alert_oe is high.
 */
`timescale 1ns/1ps
module ltal_host_model (
	// device pin
	input  wire logic i_alert_o,
	input  wire logic i_alert_oe,
	// resolved wire
	output logic      o_alert_wire
);
	// -------------------------------------------------------------
	// wire resolution
	// -------------------------------------------------------------
	// released wire goes to the pull-up level, never the last driven value
	assign o_alert_wire = i_alert_oe ? i_alert_o : 1'b1;
endmodule

// ### ltal_pkg.sv
/*
 * constants, register map and carrier types of the light threshold alert block.
 * assumes a 32-bit apb master and a conversion engine on the same clock.
 */
// Function
// - under flag after N consecutive low results
// - retention off: outputs follow current comparison
// - retention on: outputs held until user clear
// - retention bit read/write, resets to one
// - polarity zero: alert pulls pin low
// - polarity one: alert releases pin high
// - exponent zeroing in manual range reports zeros
// - comparisons always use the unmasked result
// - trip count codes 1/2/4/8, resets 00
// - over flag after N consecutive high results
// - range code 1100b means automatic ranging
package ltal_pkg;

	// ------------------------------------------------------------
	// register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0]  IDX_RESULT    = 8'h00;
	localparam logic [7:0]  IDX_CONFIG    = 8'h01;
	localparam logic [7:0]  IDX_LOW_LIM   = 8'h02;
	localparam logic [7:0]  IDX_HIGH_LIM  = 8'h03;
	localparam logic [7:0]  IDX_IRQ_STAT  = 8'h04;
	localparam logic [7:0]  IDX_IRQ_MASK  = 8'h05;
	localparam logic [7:0]  IDX_ID        = 8'h7e;
	localparam logic [31:0] ADDR_RESULT   = {22'h0, IDX_RESULT, 2'b00};
	localparam logic [31:0] ADDR_CONFIG   = {22'h0, IDX_CONFIG, 2'b00};
	localparam logic [31:0] ADDR_LOW_LIM  = {22'h0, IDX_LOW_LIM, 2'b00};
	localparam logic [31:0] ADDR_HIGH_LIM = {22'h0, IDX_HIGH_LIM, 2'b00};
	localparam logic [31:0] ADDR_IRQ_STAT = {22'h0, IDX_IRQ_STAT, 2'b00};
	localparam logic [31:0] ADDR_IRQ_MASK = {22'h0, IDX_IRQ_MASK, 2'b00};
	localparam logic [31:0] ADDR_ID       = {22'h0, IDX_ID, 2'b00};

	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic [15:0] RST_LOW_LIM   = 16'h0000;
	localparam logic [15:0] RST_HIGH_LIM  = 16'hbfff;
	localparam logic [3:0]  RST_RANGE     = 4'hc;
	localparam logic        RST_RETAIN    = 1'b1;
	localparam logic [1:0]  RST_TRIP      = 2'h0;
	localparam logic [3:0]  RANGE_AUTO    = 4'hc;
	localparam logic [3:0]  TRIP_MAX      = 4'h8;

	// ------------------------------------------------------------
	// interrupt status bit positions
	// ------------------------------------------------------------
	localparam int          IRQ_OVER      = 0;
	localparam int          IRQ_UNDER     = 1;
	localparam int          IRQ_CONV      = 2;
	localparam int          IRQ_W         = 3;

	// configuration word layout, bit 15 down to bit 0
	typedef struct packed {
		logic [3:0] range_select;
		logic [4:0] zero_pad;
		logic       over_threshold_ind;
		logic       under_threshold_ind;
		logic       report_retain;
		logic       alert_sense_invert;
		logic       exp_zero_ctrl;
		logic [1:0] trip_count;
	} ltal_cfg_t;

	// measurement word: exponent and mantissa
	typedef struct packed {
		logic [3:0]  expo;
		logic [11:0] mant;
	} ltal_meas_t;

	// apb handshake phase
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_ACK  = 1'b1
	} ltal_apb_st_t;

endpackage

// ### ltal_top.sv
/*
 * light threshold alert logic: limit compare, fault run counting, flags,
 * open-drain alert pin and apb register file.
 * assumes conversion results arrive as one-cycle strobes on i_ref_clk and an
 * external pull-up on the alert wire.
 */
`timescale 1ns/1ps
module ltal_top
	import ltal_pkg::*;
#(
	parameter logic [15:0] ID_VALUE = 16'h1234 // arbitrary identification value
)(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// conversion engine
	input  wire logic        i_conv_valid,
	input  wire ltal_meas_t  i_conv_data,
	// alert pin, open drain
	output logic             o_alert_o,
	output logic             o_alert_oe,
	// interrupt
	output logic             o_irq
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if ($bits(ltal_cfg_t) != 16) begin : g_chk
		$error("configuration word must be 16 bits");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ltal_apb_st_t           apb_st_r;
	ltal_meas_t             result_r;
	ltal_meas_t             low_lim_r;
	ltal_meas_t             high_lim_r;
	logic [3:0]             range_r;
	logic                   retain_r;
	logic                   invert_r;
	logic                   zero_r;
	logic [1:0]             trip_r;
	logic [3:0]             over_cnt_r;
	logic [3:0]             under_cnt_r;
	logic                   over_flag_r;
	logic                   under_flag_r;
	logic [IRQ_W-1:0]       irq_stat_r;
	logic [IRQ_W-1:0]       irq_mask_r;
	logic                   done_edge;
	logic                   wr_en;
	logic                   rd_en;
	logic                   cfg_touch;
	logic [3:0]             trip_need;
	logic [26:0]            res_lux;
	logic [26:0]            low_lux;
	logic [26:0]            high_lux;
	logic                   is_over;
	logic                   is_under;
	logic [3:0]             over_cnt_nxt;
	logic [3:0]             under_cnt_nxt;
	logic                   over_hit;
	logic                   under_hit;
	logic                   alert_act;
	logic [IRQ_W-1:0]       irq_ev;
	ltal_cfg_t              cfg_view;
	ltal_meas_t             result_view;
	logic [31:0]            rd_data;
	logic                   addr_ok;

	// scale mantissa by exponent so registers with different exponents compare in one unit
	function automatic logic [26:0] to_lux(input ltal_meas_t m);
		to_lux = {15'h0000, m.mant} << m.expo;
	endfunction

	// ------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ------------------------------------------------------------
	assign done_edge = i_psel && i_penable && o_pready;
	assign wr_en     = done_edge && i_pwrite && !o_pslverr;
	assign rd_en     = done_edge && !i_pwrite && !o_pslverr;
	// any completed access to the configuration word is the user clear event
	assign cfg_touch = (wr_en || rd_en) && (i_paddr == ADDR_CONFIG);

	// handshake: ready comes one cycle into the access phase and lasts one cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			apb_st_r <= ST_IDLE;
			o_pready <= 1'b0;
		end else begin
			case (apb_st_r)
				ST_IDLE: begin
					if (i_psel && i_penable) begin
						apb_st_r <= ST_ACK;
						o_pready <= 1'b1;
					end
				end
				ST_ACK: begin
					apb_st_r <= ST_IDLE;
					o_pready <= 1'b0;
				end
				default: begin
					apb_st_r <= ST_IDLE;
					o_pready <= 1'b0;
				end
			endcase
		end
	end

	// read view of the configuration word, flags live here too
	always_comb begin
		cfg_view                     = '0;
		cfg_view.range_select        = range_r;
		cfg_view.over_threshold_ind  = over_flag_r;
		cfg_view.under_threshold_ind = under_flag_r;
		cfg_view.report_retain       = retain_r;
		cfg_view.alert_sense_invert  = invert_r;
		cfg_view.exp_zero_ctrl       = zero_r;
		cfg_view.trip_count          = trip_r;
	end

	// reported result: exponent zeroed only in a manual range
	always_comb begin
		result_view = result_r;
		if (zero_r && (range_r < RANGE_AUTO)) begin
			result_view.expo = 4'h0;
		end
	end

	// address decode
	always_comb begin
		addr_ok = 1'b1;
		rd_data = 32'h0000_0000;
		if (i_paddr == ADDR_RESULT) begin
			rd_data = {16'h0000, result_view};
		end else if (i_paddr == ADDR_CONFIG) begin
			rd_data = {16'h0000, cfg_view};
		end else if (i_paddr == ADDR_LOW_LIM) begin
			rd_data = {16'h0000, low_lim_r};
		end else if (i_paddr == ADDR_HIGH_LIM) begin
			rd_data = {16'h0000, high_lim_r};
		end else if (i_paddr == ADDR_IRQ_STAT) begin
			rd_data = {29'h0, irq_stat_r};
		end else if (i_paddr == ADDR_IRQ_MASK) begin
			rd_data = {29'h0, irq_mask_r};
		end else if (i_paddr == ADDR_ID) begin
			rd_data = {16'h0000, ID_VALUE};
		end else begin
			addr_ok = 1'b0;
		end
	end

	// read data and error captured when ready is raised
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (apb_st_r == ST_IDLE && i_psel && i_penable) begin
			o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_data;
			o_pslverr <= !addr_ok;
		end else begin
			o_pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// writable registers
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			low_lim_r  <= RST_LOW_LIM;
			high_lim_r <= RST_HIGH_LIM;
			range_r    <= RST_RANGE;
			retain_r   <= RST_RETAIN;
			invert_r   <= 1'b0;
			zero_r     <= 1'b0;
			trip_r     <= RST_TRIP;
			irq_mask_r <= '0;
		end else if (wr_en) begin
			if (i_paddr == ADDR_CONFIG) begin
				range_r  <= i_pwdata[15:12];
				retain_r <= i_pwdata[4];
				invert_r <= i_pwdata[3];
				zero_r   <= i_pwdata[2];
				trip_r   <= i_pwdata[1:0];
			end else if (i_paddr == ADDR_LOW_LIM) begin
				low_lim_r <= i_pwdata[15:0];
			end else if (i_paddr == ADDR_HIGH_LIM) begin
				high_lim_r <= i_pwdata[15:0];
			end else if (i_paddr == ADDR_IRQ_MASK) begin
				irq_mask_r <= i_pwdata[IRQ_W-1:0];
			end
		end
	end

	// result capture keeps the raw word; masking is only on the read path
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			result_r <= '0;
		end else if (i_conv_valid) begin
			result_r <= i_conv_data;
		end
	end

	// ------------------------------------------------------------
	// limit comparison and fault run counting
	// ------------------------------------------------------------
	assign res_lux  = to_lux(i_conv_data);
	assign low_lux  = to_lux(low_lim_r);
	assign high_lux = to_lux(high_lim_r);
	assign is_over  = res_lux > high_lux;
	assign is_under = res_lux < low_lux;

	// trip count code to run length
	always_comb begin
		case (trip_r)
			2'h0:    trip_need = 4'h1;
			2'h1:    trip_need = 4'h2;
			2'h2:    trip_need = 4'h4;
			default: trip_need = TRIP_MAX;
		endcase
	end

	// run counters saturate at eight so a long run cannot wrap back to zero
	always_comb begin
		over_cnt_nxt  = over_cnt_r;
		under_cnt_nxt = under_cnt_r;
		if (i_conv_valid) begin
			over_cnt_nxt  = is_over ? ((over_cnt_r == TRIP_MAX) ? TRIP_MAX : over_cnt_r + 4'h1) : 4'h0;
			under_cnt_nxt = is_under ? ((under_cnt_r == TRIP_MAX) ? TRIP_MAX : under_cnt_r + 4'h1) : 4'h0;
		end
	end
	assign over_hit  = i_conv_valid && (over_cnt_nxt >= trip_need);
	assign under_hit = i_conv_valid && (under_cnt_nxt >= trip_need);

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			over_cnt_r  <= 4'h0;
			under_cnt_r <= 4'h0;
		end else begin
			over_cnt_r  <= over_cnt_nxt;
			under_cnt_r <= under_cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// flags: transparent or held; a hit in the clear cycle wins
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			over_flag_r  <= 1'b0;
			under_flag_r <= 1'b0;
		end else if (!retain_r) begin
			if (i_conv_valid) begin
				over_flag_r  <= over_hit;
				under_flag_r <= under_hit;
			end
		end else begin
			over_flag_r  <= over_hit || (over_flag_r && !cfg_touch);
			under_flag_r <= under_hit || (under_flag_r && !cfg_touch);
		end
	end

	// ------------------------------------------------------------
	// alert pin: only ever drives low, pull-up makes the high level
	// ------------------------------------------------------------
	assign alert_act = over_flag_r || under_flag_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_alert_o  <= 1'b0;
			o_alert_oe <= 1'b0;
		end else begin
			o_alert_o  <= 1'b0;
			o_alert_oe <= invert_r ? !alert_act : alert_act;
		end
	end

	// ------------------------------------------------------------
	// interrupt: sticky status, write one to clear, set wins
	// ------------------------------------------------------------
	assign irq_ev = {i_conv_valid, under_hit, over_hit};
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			irq_stat_r <= '0;
		end else if (wr_en && i_paddr == ADDR_IRQ_STAT) begin
			irq_stat_r <= irq_ev | (irq_stat_r & ~i_pwdata[IRQ_W-1:0]);
		end else begin
			irq_stat_r <= irq_ev | irq_stat_r;
		end
	end

	// level output, one cycle behind the status register
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_under_set;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		under_hit |=> under_flag_r;
	endproperty
	a_under_set: assert property (p_under_set) else $error("under flag not set after fault run");

	property p_transparent;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!retain_r && i_conv_valid && !is_over) |=> !over_flag_r;
	endproperty
	a_transparent: assert property (p_transparent) else $error("over flag held in transparent style");

	property p_hold;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(retain_r && over_flag_r && !cfg_touch && $stable(retain_r)) |=> over_flag_r;
	endproperty
	a_hold: assert property (p_hold) else $error("held over flag dropped without clear");

	property p_retain_wr;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(wr_en && i_paddr == ADDR_CONFIG) |=> (retain_r == $past(i_pwdata[4]));
	endproperty
	a_retain_wr: assert property (p_retain_wr) else $error("retention bit write lost");

	property p_pol_low;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!invert_r && alert_act) ##1 (!invert_r && alert_act) |-> o_alert_oe && !o_alert_o;
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("alert not pulled low");

	property p_pol_high;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(invert_r && alert_act) ##1 (invert_r && alert_act) |-> !o_alert_oe;
	endproperty
	a_pol_high: assert property (p_pol_high) else $error("alert pin not released");

	property p_zero_exp;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(rd_en && i_paddr == ADDR_RESULT && zero_r && range_r < RANGE_AUTO) |-> o_prdata[15:12] == 4'h0;
	endproperty
	a_zero_exp: assert property (p_zero_exp) else $error("exponent reported while zeroing");

	property p_trip_eight;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(trip_r == 2'h3 && i_conv_valid && over_cnt_r < 4'h7) |-> !over_hit;
	endproperty
	a_trip_eight: assert property (p_trip_eight) else $error("trip of eight fired early");

	property p_run_reset;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_conv_valid && !is_under) |=> under_cnt_r == 4'h0;
	endproperty
	a_run_reset: assert property (p_run_reset) else $error("fault run not restarted");

endmodule
